// file: hdl/ssp_uart.sv
// Second serial port: four frame modes, address recognition, APB registers
//
// Behaviour
// - Mask bit one compares that address bit
// - Mask bit zero makes address bit don't-care
// - All-zero mask accepts any address
// - Two mode bits select frame and rate
// - Bit seven is mode or sticky framing error
// - Modes 2/3 multiprocessor: ninth zero, no flag
// - Mode 1 multiprocessor: bad stop, no flag
// - Mode 0 multiprocessor bit picks /12 or /4
// - Receive only while receive enable set
// - Modes 2/3 send software ninth bit
// - Ninth field: bit9, mode1 stop with multiprocessor bit clear, mode0 none
// - Transmit flag at bit eight or stop start
// - Receive flag at bit eight or mid-stop
// - Buffer reads receive, writes transmit register
// - Transmit activity until transmit flag sets
// - Receive activity until the frame's last sample, flag set or not
// - Doubler doubles rate in modes 1-3
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`include "ssp_params.svh"
`default_nettype none

module ssp_uart
    import ssp_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic rxd_in,
    output logic rxd_out,
    output logic rxd_oe,
    output logic txd_out
);

    ssp_state_t q;
    ssp_state_t nxt_q;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        hit = (a[ADDR_W-1:2] == {{(ADDR_W-10){1'b0}}, idx}) && (a[1:0] == 2'b00);
    endfunction

    // Clocks per bit; variable rate stands in for an external timer as a reload value
    function automatic logic [15:0] bit_time(input logic [1:0] mode, input logic mp,
                                             input logic dbl, input logic [7:0] rld);
        logic [15:0] base;
        base = {8'h00, rld} + 16'h0001;
        case (mode)
            2'b00: bit_time = mp ? `SSP_M0_FAST : `SSP_M0_SLOW;
            2'b10: bit_time = dbl ? `SSP_M2_FAST : `SSP_M2_SLOW;
            default: bit_time = base << (dbl ? `SSP_VAR_SHIFT - 1 : `SSP_VAR_SHIFT);
        endcase
    endfunction

    logic acc;
    logic wr;
    logic [1:0] mode;
    logic [15:0] bt;
    logic [15:0] half;
    logic tx_start;
    logic tx_ev;
    logic rx_ev;
    logic fe_ev;
    logic stop_bit;
    logic ninth;
    logic [7:0] rx_data;
    logic addr_ok;
    logic rx_ok;
    logic [7:0] rdata;
    logic mapped;

    always_comb begin
        nxt_q = q;
        acc = psel && penable && !q.pready;
        wr = psel && penable && q.pready && pwrite;
        mode = {q.sm0, q.sm1};
        bt = bit_time(mode, q.sm2, q.dbl, q.reload);
        half = bt >> 1;
        tx_ev = 1'b0;
        rx_ev = 1'b0;
        fe_ev = 1'b0;
        stop_bit = rxd_in;
        ninth = q.rx_sh[8];
        rx_data = (mode == 2'b01) ? q.rx_sh[8:1] : q.rx_sh[7:0];
        addr_ok = ((rx_data ^ q.saddr) & q.sadden) == 8'h00;
        rx_ok = 1'b0;
        rdata = 8'h00;
        mapped = 1'b1;
        tx_start = wr && hit(paddr, `SSP_IDX_BUF) && (q.tx_st == SSP_TX_IDLE) &&
                   !(mode == 2'b00 && q.rx_st == SSP_RX_SYNC);

        // Read mux; one wait state lets the data settle into a flip-flop
        if (hit(paddr, `SSP_IDX_SADDR)) begin
            rdata = q.saddr;
        end else if (hit(paddr, `SSP_IDX_MASK)) begin
            rdata = q.sadden;
        end else if (hit(paddr, `SSP_IDX_CTL)) begin
            rdata = {q.fe_sel ? q.fe : q.sm0, q.sm1, q.sm2, q.ren, q.tb8, q.rb8, q.ti, q.ri};
        end else if (hit(paddr, `SSP_IDX_BUF)) begin
            rdata = q.rxbuf;
        end else if (hit(paddr, `SSP_IDX_STAT)) begin
            rdata[`SSP_STAT_TXACT] = q.tx_act;
            rdata[`SSP_STAT_RXACT] = q.rx_act;
        end else if (hit(paddr, `SSP_IDX_AUX)) begin
            rdata[`SSP_AUX_FESEL] = q.fe_sel;
            rdata[`SSP_AUX_DBL] = q.dbl;
        end else if (hit(paddr, `SSP_IDX_RELOAD)) begin
            rdata = q.reload;
        end else if (hit(paddr, `SSP_IDX_IRQST)) begin
            rdata = {5'b00000, q.irq_st};
        end else if (hit(paddr, `SSP_IDX_IRQMSK)) begin
            rdata = q.irq_mask;
        end else begin
            mapped = 1'b0;
        end
        nxt_q.pready = acc;
        if (acc) begin
            nxt_q.prdata = pwrite ? 8'h00 : rdata;
            nxt_q.pslverr = !mapped;
        end else begin
            nxt_q.pslverr = 1'b0;
        end

        // Register writes; hardware events below override, so a set beats a clear
        if (wr) begin
            if (hit(paddr, `SSP_IDX_SADDR)) begin
                nxt_q.saddr = pwdata[7:0];
            end
            if (hit(paddr, `SSP_IDX_MASK)) begin
                nxt_q.sadden = pwdata[7:0];
            end
            if (hit(paddr, `SSP_IDX_CTL)) begin
                if (q.fe_sel) begin
                    nxt_q.fe = q.fe & pwdata[`SSP_CTL_B7];
                end else begin
                    nxt_q.sm0 = pwdata[`SSP_CTL_B7];
                end
                nxt_q.sm1 = pwdata[`SSP_CTL_MODE1];
                nxt_q.sm2 = pwdata[`SSP_CTL_MP];
                nxt_q.ren = pwdata[`SSP_CTL_REN];
                nxt_q.tb8 = pwdata[`SSP_CTL_TB8];
                nxt_q.rb8 = pwdata[`SSP_CTL_RB8];
                nxt_q.ti = q.ti & pwdata[`SSP_CTL_TI];
                nxt_q.ri = q.ri & pwdata[`SSP_CTL_RI];
            end
            if (hit(paddr, `SSP_IDX_AUX)) begin
                nxt_q.fe_sel = pwdata[`SSP_AUX_FESEL];
                nxt_q.dbl = pwdata[`SSP_AUX_DBL];
            end
            if (hit(paddr, `SSP_IDX_RELOAD)) begin
                nxt_q.reload = pwdata[7:0];
            end
            if (hit(paddr, `SSP_IDX_IRQST)) begin
                nxt_q.irq_st = q.irq_st & ~pwdata[2:0];
            end
            if (hit(paddr, `SSP_IDX_IRQMSK)) begin
                nxt_q.irq_mask = pwdata[7:0];
            end
            if (hit(paddr, `SSP_IDX_BUF)) begin
                nxt_q.txbuf = pwdata[7:0];
            end
        end

        // Transmitter; a write while busy only updates the buffer
        case (q.tx_st)
            SSP_TX_IDLE: begin
                if (tx_start) begin
                    nxt_q.tx_cnt = 16'h0000;
                    nxt_q.tx_st = SSP_TX_SHIFT;
                    nxt_q.tx_act = 1'b1;
                    if (mode == 2'b00) begin
                        nxt_q.tx_sh = {3'b111, pwdata[7:0]};
                        nxt_q.tx_left = 4'h8;
                    end else if (mode == 2'b01) begin
                        nxt_q.tx_sh = {2'b11, pwdata[7:0], 1'b0};
                        nxt_q.tx_left = 4'hA;
                    end else begin
                        nxt_q.tx_sh = {1'b1, q.tb8, pwdata[7:0], 1'b0};
                        nxt_q.tx_left = 4'hB;
                    end
                end
            end
            SSP_TX_SHIFT: begin
                nxt_q.tx_cnt = q.tx_cnt + 16'h0001;
                if (q.tx_cnt == bt - 16'h0001) begin
                    nxt_q.tx_cnt = 16'h0000;
                    nxt_q.tx_sh = {1'b1, q.tx_sh[10:1]};
                    nxt_q.tx_left = q.tx_left - 4'h1;
                    if (mode == 2'b00) begin
                        if (q.tx_left == 4'h1) begin
                            tx_ev = 1'b1;
                            nxt_q.tx_st = SSP_TX_IDLE;
                        end
                    end else begin
                        if (q.tx_left == 4'h2) begin
                            tx_ev = 1'b1;
                        end
                        if (q.tx_left == 4'h1) begin
                            nxt_q.tx_st = SSP_TX_IDLE;
                        end
                    end
                end
            end
            default: nxt_q.tx_st = SSP_TX_IDLE;
        endcase

        // Receiver
        nxt_q.rx_prev = rxd_in;
        if (!q.ren) begin
            nxt_q.rx_st = SSP_RX_IDLE;
            nxt_q.rx_act = 1'b0;
        end else begin
            case (q.rx_st)
                SSP_RX_IDLE: begin
                    nxt_q.rx_cnt = 16'h0000;
                    nxt_q.rx_got = 4'h0;
                    if (mode == 2'b00) begin
                        // Shift mode starts on its own once the last byte was taken
                        if (!q.ri && q.tx_st == SSP_TX_IDLE && !tx_start) begin
                            nxt_q.rx_st = SSP_RX_SYNC;
                            nxt_q.rx_act = 1'b1;
                        end
                    end else if (q.rx_prev && !rxd_in) begin
                        nxt_q.rx_st = SSP_RX_START;
                        nxt_q.rx_act = 1'b1;
                    end
                end
                SSP_RX_START: begin
                    nxt_q.rx_cnt = q.rx_cnt + 16'h0001;
                    if (q.rx_cnt == half - 16'h0001) begin
                        nxt_q.rx_cnt = 16'h0000;
                        // A glitch shorter than half a bit is dropped
                        if (!rxd_in) begin
                            nxt_q.rx_st = SSP_RX_DATA;
                        end else begin
                            nxt_q.rx_st = SSP_RX_IDLE;
                            nxt_q.rx_act = 1'b0;
                        end
                    end
                end
                SSP_RX_DATA: begin
                    nxt_q.rx_cnt = q.rx_cnt + 16'h0001;
                    if (q.rx_cnt == bt - 16'h0001) begin
                        nxt_q.rx_cnt = 16'h0000;
                        nxt_q.rx_sh = {rxd_in, q.rx_sh[8:1]};
                        nxt_q.rx_got = q.rx_got + 4'h1;
                        if (q.rx_got == ((mode == 2'b01) ? 4'h7 : 4'h8)) begin
                            nxt_q.rx_st = SSP_RX_STOP;
                        end
                    end
                end
                SSP_RX_STOP: begin
                    nxt_q.rx_cnt = q.rx_cnt + 16'h0001;
                    if (q.rx_cnt == bt - 16'h0001) begin
                        nxt_q.rx_st = SSP_RX_IDLE;
                        nxt_q.rx_act = 1'b0;
                        fe_ev = !stop_bit;
                        if (mode == 2'b01) begin
                            rx_ok = !q.sm2 || stop_bit;
                        end else begin
                            rx_ok = !q.sm2 || (ninth && addr_ok);
                        end
                        if (rx_ok) begin
                            rx_ev = 1'b1;
                            nxt_q.rxbuf = rx_data;
                            if (mode != 2'b01) begin
                                nxt_q.rb8 = ninth;
                            end else if (!q.sm2) begin
                                nxt_q.rb8 = stop_bit;
                            end
                        end
                    end
                end
                SSP_RX_SYNC: begin
                    nxt_q.rx_cnt = q.rx_cnt + 16'h0001;
                    if (q.rx_cnt == bt - 16'h0001) begin
                        nxt_q.rx_cnt = 16'h0000;
                        nxt_q.rx_sh = {rxd_in, q.rx_sh[8:1]};
                        nxt_q.rx_got = q.rx_got + 4'h1;
                        if (q.rx_got == 4'h7) begin
                            nxt_q.rxbuf = {rxd_in, q.rx_sh[8:2]};
                            nxt_q.rx_st = SSP_RX_IDLE;
                            nxt_q.rx_act = 1'b0;
                            rx_ev = 1'b1;
                        end
                    end
                end
                default: nxt_q.rx_st = SSP_RX_IDLE;
            endcase
        end

        // Events
        if (tx_ev) begin
            nxt_q.ti = 1'b1;
            nxt_q.tx_act = 1'b0;
        end
        if (rx_ev) begin
            nxt_q.ri = 1'b1;
            nxt_q.rx_act = 1'b0;
        end
        if (fe_ev) begin
            nxt_q.fe = 1'b1;
        end
        nxt_q.irq_st = nxt_q.irq_st | {fe_ev, rx_ev, tx_ev};
        nxt_q.irq = |(nxt_q.irq_st & nxt_q.irq_mask[2:0]);

        // Pins follow the next state so they leave flip-flops in step with it
        nxt_q.rxd_oe = 1'b0;
        nxt_q.rxd_out = 1'b1;
        if (nxt_q.tx_st == SSP_TX_SHIFT && mode == 2'b00) begin
            nxt_q.txd = nxt_q.tx_cnt >= half;
            nxt_q.rxd_oe = 1'b1;
            nxt_q.rxd_out = nxt_q.tx_sh[0];
        end else if (nxt_q.tx_st == SSP_TX_SHIFT) begin
            nxt_q.txd = nxt_q.tx_sh[0];
        end else if (nxt_q.rx_st == SSP_RX_SYNC) begin
            nxt_q.txd = nxt_q.rx_cnt >= half;
        end else begin
            nxt_q.txd = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            q <= '0;
            q.reload <= `SSP_RST_RELOAD;
            q.sadden <= `SSP_RST_BYTE;
            q.tx_st <= SSP_TX_IDLE;
            q.rx_st <= SSP_RX_IDLE;
            q.rx_prev <= 1'b1;
            q.txd <= 1'b1;
            q.rxd_out <= 1'b1;
        end else begin
            q <= nxt_q;
        end
    end

    assign prdata = {24'h00_0000, q.prdata};
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign irq = q.irq;
    assign rxd_out = q.rxd_out;
    assign rxd_oe = q.rxd_oe;
    assign txd_out = q.txd;

    a_addr_match: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(q.ri) && q.sm0 && q.sm2 |-> (((q.rxbuf ^ q.saddr) & q.sadden) == 8'h00) && q.rb8)
        else $error("Address frame accepted without a mask match");
    a_rx_disabled: assert property (@(posedge mclk) disable iff (!resetn)
        !q.ren |=> q.rx_st == SSP_RX_IDLE && !q.rx_act)
        else $error("Receiver active while disabled");
    a_tx_flag_act: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(q.ti) |-> !q.tx_act && $past(q.tx_act))
        else $error("Transmit flag and activity out of step");
    a_rx_flag_act: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(q.ri) |-> !q.rx_act && $past(q.rx_act))
        else $error("Receive flag and activity out of step");
    a_buf_start: assert property (@(posedge mclk) disable iff (!resetn)
        psel && penable && pready && pwrite && hit(paddr, `SSP_IDX_BUF) &&
        q.tx_st == SSP_TX_IDLE && q.rx_st != SSP_RX_SYNC
        |=> q.tx_act && q.txbuf == $past(pwdata[7:0]) && $stable(q.rxbuf))
        else $error("Buffer write did not start a frame");
    a_ninth_sent: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(q.tx_act) && q.sm0 |-> q.tx_sh[9] == $past(q.tb8) && !q.tx_sh[0])
        else $error("Ninth bit not taken from software value");
    a_m0_rate: assert property (@(posedge mclk) disable iff (!resetn)
        q.tx_st == SSP_TX_SHIFT && !q.sm0 && !q.sm1
        |-> q.tx_cnt < (q.sm2 ? `SSP_M0_FAST : `SSP_M0_SLOW))
        else $error("Shift mode bit time wrong");
    a_m2_rate: assert property (@(posedge mclk) disable iff (!resetn)
        q.tx_st == SSP_TX_SHIFT && q.sm0 && !q.sm1
        |-> q.tx_cnt < (q.dbl ? `SSP_M2_FAST : `SSP_M2_SLOW))
        else $error("Mode 2 bit time wrong");
    a_fe_sticky: assert property (@(posedge mclk) disable iff (!resetn)
        q.fe && !(psel && penable && pready && pwrite && hit(paddr, `SSP_IDX_CTL)) |=> q.fe)
        else $error("Framing error cleared by hardware");

endmodule // ssp_uart

`default_nettype wire

// file: shared/ssp_params.svh
// Register indices, field positions, reset values and bit-time counts of the serial port
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH

// Register indices; byte address is four times the index
`define SSP_IDX_SADDR   8'hAA
`define SSP_IDX_MASK    8'hBA
`define SSP_IDX_CTL     8'hC0
`define SSP_IDX_BUF     8'hC1
`define SSP_IDX_STAT    8'hC5
`define SSP_IDX_AUX     8'hE0
`define SSP_IDX_RELOAD  8'hE1
`define SSP_IDX_IRQST   8'hE2
`define SSP_IDX_IRQMSK  8'hE3

// Control register fields
`define SSP_CTL_B7      7
`define SSP_CTL_MODE1   6
`define SSP_CTL_MP      5
`define SSP_CTL_REN     4
`define SSP_CTL_TB8     3
`define SSP_CTL_RB8     2
`define SSP_CTL_TI      1
`define SSP_CTL_RI      0

// Status register fields
`define SSP_STAT_TXACT  3
`define SSP_STAT_RXACT  2

// Auxiliary control fields
`define SSP_AUX_FESEL   0
`define SSP_AUX_DBL     1

// Interrupt status fields
`define SSP_IRQ_TX      0
`define SSP_IRQ_RX      1
`define SSP_IRQ_FE      2

// Reset values
`define SSP_RST_BYTE    8'h00
`define SSP_RST_RELOAD  8'h00

// Oscillator clocks per bit, and the shift applied to the variable-rate reload
`define SSP_M0_SLOW     16'h000C
`define SSP_M0_FAST     16'h0004
`define SSP_M2_SLOW     16'h0040
`define SSP_M2_FAST     16'h0020
`define SSP_VAR_SHIFT   4

`endif

// file: shared/ssp_pkg.sv
// Types of the second serial port
package ssp_pkg;

    typedef enum logic [1:0] {
        SSP_TX_IDLE  = 2'b01,
        SSP_TX_SHIFT = 2'b10
    } ssp_tx_st_t;

    typedef enum logic [4:0] {
        SSP_RX_IDLE  = 5'b00001,
        SSP_RX_START = 5'b00010,
        SSP_RX_DATA  = 5'b00100,
        SSP_RX_STOP  = 5'b01000,
        SSP_RX_SYNC  = 5'b10000
    } ssp_rx_st_t;

    typedef struct packed {
        logic [7:0] sadden;
        logic [7:0] saddr;
        logic [7:0] reload;
        logic [7:0] txbuf;
        logic [7:0] rxbuf;
        logic [7:0] irq_mask;
        logic [7:0] prdata;
        logic sm0;
        logic fe;
        logic sm1;
        logic sm2;
        logic ren;
        logic tb8;
        logic rb8;
        logic ti;
        logic ri;
        logic fe_sel;
        logic dbl;
        logic [2:0] irq_st;
        logic tx_act;
        logic rx_act;
        ssp_tx_st_t tx_st;
        logic [15:0] tx_cnt;
        logic [10:0] tx_sh;
        logic [3:0] tx_left;
        ssp_rx_st_t rx_st;
        logic [15:0] rx_cnt;
        logic [8:0] rx_sh;
        logic [3:0] rx_got;
        logic rx_prev;
        logic txd;
        logic rxd_out;
        logic rxd_oe;
        logic pready;
        logic pslverr;
        logic irq;
    } ssp_state_t;

endpackage

// file: dv/ssp_peer.sv
// Remote serial peer: drives whole frames onto the receive line
`timescale 1ns/1ps
`default_nettype none

module ssp_peer (
    input wire logic mclk,
    output logic line
);
    // Async idle level is high, so the line rests there between frames
    initial line = 1'b1;

    // Bits leave LSB first, start bit included in the frame word
    task automatic send(input logic [10:0] frame, input int nbits, input int bt);
        for (int i = 0; i < nbits; i++) begin
            @(posedge mclk);
            line <= frame[i];
            repeat (bt - 1) @(posedge mclk);
        end
        @(posedge mclk);
        line <= 1'b1;
    endtask
endmodule // ssp_peer

`default_nettype wire

// file: dv/ssp_uart_test.sv
// Self-checking bench of the second serial port
`timescale 1ns/1ps
`include "ssp_params.svh"
`default_nettype none

module second_serial_port_uart_test;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, irq, rxd_out, rxd_oe, txd_out, peer_line, rxd_in;
    int errors = 0;
    int compares = 0;

    always #5 mclk = ~mclk;
    // Shared data pin: the block wins while it drives in shift mode
    assign rxd_in = rxd_oe ? rxd_out : peer_line;

    ssp_uart dut_u (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
        .txd_out(txd_out));
    ssp_peer peer_u (.mclk(mclk), .line(peer_line));

    task automatic stop_test();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h00_0000, wd};
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) begin
            errors++;
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_bit(input logic [7:0] idx, input int b);
        int n;
        for (n = 0; n < 400; n++) begin
            apb(1'b0, idx, 8'h00);
            if (rd[b] === 1'b1) break;
        end
        if (n == 400) begin
            errors++;
            stop_test();
        end
    endtask

    task automatic until_txd(input logic v, inout int n);
        while (txd_out !== v && n < 2000) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 2000) begin
            errors++;
            stop_test();
        end
    endtask

    task automatic t_regs();
        apb(1'b0, `SSP_IDX_CTL, 8'h00);
        chk("control", 32'h0000_0000, rd);
        apb(1'b0, `SSP_IDX_STAT, 8'h00);
        chk("status", 32'h0000_0000, rd);
        apb(1'b1, 8'h10, 8'h5A);
        chk("unmapped error", 1, err);
        apb(1'b1, `SSP_IDX_MASK, 8'hF0);
        apb(1'b0, `SSP_IDX_MASK, 8'h00);
        chk("mask", 32'h0000_00F0, rd);
    endtask

    task automatic t_tx(input logic [7:0] ctl, input logic [7:0] aux, input logic [7:0] d,
                        input int nb, input int bt);
        logic [10:0] f;
        f = (nb == 11) ? {1'b1, ctl[`SSP_CTL_TB8], d, 1'b0} : {2'b11, d, 1'b0};
        apb(1'b1, `SSP_IDX_AUX, aux);
        apb(1'b1, `SSP_IDX_CTL, ctl);
        apb(1'b1, `SSP_IDX_BUF, d);
        repeat (bt / 2) @(posedge mclk);
        for (int i = 0; i < nb; i++) begin
            @(posedge mclk);
            chk("tx bit", f[i], txd_out);
            repeat (bt - 1) @(posedge mclk);
        end
        apb(1'b0, `SSP_IDX_CTL, 8'h00);
        chk("tx flags", {24'h00_0000, ctl | 8'h02}, rd);
        apb(1'b0, `SSP_IDX_STAT, 8'h00);
        chk("tx idle", 0, rd[`SSP_STAT_TXACT]);
        // Clearing the done flag by writing zero to it
        apb(1'b1, `SSP_IDX_CTL, ctl);
        repeat (bt) @(posedge mclk);
    endtask

    task automatic t_m0(input logic mp, input int per);
        int n, k;
        apb(1'b1, `SSP_IDX_CTL, {2'b00, mp, 5'b00000});
        apb(1'b1, `SSP_IDX_BUF, 8'h80);
        apb(1'b0, `SSP_IDX_STAT, 8'h00);
        chk("tx activity", 1, rd[`SSP_STAT_TXACT]);
        chk("data pin driven", 1, rxd_oe);
        n = 0;
        until_txd(1'b0, n);
        until_txd(1'b1, n);
        k = n;
        // Low bits of the byte are zero, so the first rising clock shows a zero either way
        chk("shift data", 0, rxd_out);
        until_txd(1'b0, n);
        until_txd(1'b1, n);
        chk("shift period", per, n - k);
        wait_bit(`SSP_IDX_CTL, `SSP_CTL_TI);
        chk("data pin released", 0, rxd_oe);
        apb(1'b1, `SSP_IDX_CTL, 8'h00);
    endtask

    // Shift-mode receive: the peer changes its bit each 12 clocks, the block samples at bit end
    task automatic t_m0_rx();
        apb(1'b1, `SSP_IDX_CTL, 8'h14);
        peer_u.send({3'b111, 8'h4B}, 8, 12);
        apb(1'b0, `SSP_IDX_CTL, 8'h00);
        chk("shift rx flags", 32'h0000_0015, rd);
        apb(1'b0, `SSP_IDX_BUF, 8'h00);
        chk("shift rx data", 32'h0000_004B, rd);
        apb(1'b1, `SSP_IDX_CTL, 8'h00);
        apb(1'b1, `SSP_IDX_IRQST, 8'h07);
    endtask

    task automatic t_rx();
        apb(1'b1, `SSP_IDX_IRQMSK, 8'h02);
        apb(1'b1, `SSP_IDX_CTL, 8'h50);
        fork
            peer_u.send({2'b11, 8'hC3, 1'b0}, 10, 16);
            begin
                repeat (60) @(posedge mclk);
                apb(1'b0, `SSP_IDX_STAT, 8'h00);
                chk("rx activity", 1, rd[`SSP_STAT_RXACT]);
            end
        join
        chk("rx irq", 1, irq);
        apb(1'b0, `SSP_IDX_CTL, 8'h00);
        chk("rx flags", 32'h0000_0055, rd);
        apb(1'b0, `SSP_IDX_BUF, 8'h00);
        chk("rx data", 32'h0000_00C3, rd);
        apb(1'b1, `SSP_IDX_IRQST, 8'h02);
        repeat (2) @(posedge mclk);
        #1;
        chk("irq cleared", 0, irq);
        apb(1'b1, `SSP_IDX_CTL, 8'h40);
        peer_u.send({2'b11, 8'h3C, 1'b0}, 10, 16);
        apb(1'b0, `SSP_IDX_BUF, 8'h00);
        chk("rx disabled", 32'h0000_00C3, rd);
        apb(1'b1, `SSP_IDX_AUX, 8'h01);
        apb(1'b1, `SSP_IDX_CTL, 8'h70);
        peer_u.send({2'b10, 8'h11, 1'b0}, 10, 16);
        apb(1'b0, `SSP_IDX_CTL, 8'h00);
        chk("framing error", 1, rd[`SSP_CTL_B7]);
        chk("gated done", 0, rd[`SSP_CTL_RI]);
        apb(1'b1, `SSP_IDX_CTL, 8'h70);
        apb(1'b0, `SSP_IDX_CTL, 8'h00);
        chk("framing cleared", 0, rd[`SSP_CTL_B7]);
    endtask

    task automatic mp_case(input logic [7:0] m, input logic [7:0] a, input logic nin,
                           input logic exp);
        apb(1'b1, `SSP_IDX_MASK, m);
        peer_u.send({1'b1, nin, a, 1'b0}, 11, 16);
        apb(1'b0, `SSP_IDX_CTL, 8'h00);
        chk("address done", exp, rd[`SSP_CTL_RI]);
        if (exp) begin
            chk("ninth bit", nin, rd[`SSP_CTL_RB8]);
        end
        apb(1'b1, `SSP_IDX_CTL, 8'hF0);
    endtask

    task automatic t_mp();
        apb(1'b1, `SSP_IDX_AUX, 8'h00);
        apb(1'b1, `SSP_IDX_SADDR, 8'h50);
        apb(1'b1, `SSP_IDX_CTL, 8'hF0);
        mp_case(8'hF0, 8'h5A, 1'b1, 1'b1);
        mp_case(8'hF0, 8'h6A, 1'b1, 1'b0);
        mp_case(8'hF0, 8'h5A, 1'b0, 1'b0);
        mp_case(8'h00, 8'hE7, 1'b1, 1'b1);
    endtask

    initial begin
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        t_regs();
        t_tx(8'h40, 8'h00, 8'hA5, 10, 16);
        t_tx(8'h40, 8'h02, 8'h3C, 10, 8);
        t_tx(8'h88, 8'h00, 8'h96, 11, 64);
        t_tx(8'h80, 8'h02, 8'h69, 11, 32);
        t_tx(8'hC8, 8'h00, 8'h5A, 11, 16);
        t_m0(1'b0, 12);
        t_m0(1'b1, 4);
        t_m0_rx();
        t_rx();
        t_mp();
        stop_test();
    end

    initial begin
        repeat (100000) @(posedge mclk);
        errors++;
        stop_test();
    end
endmodule // second_serial_port_uart_test

`default_nettype wire
